// ### hw/rpq_pkg.sv
`default_nettype none
package rpq_pkg;
  // ----------------------------------------------------------------
  // Framing characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_SOP_IN = 8'h3C;
  localparam logic [7:0] CH_SOP_OUT = 8'h3E;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_QRY = 8'h3F;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_VIRT_UC = 8'h56;
  localparam logic [7:0] CH_VIRT_LC = 8'h76;
  localparam logic [7:0] CH_D0 = 8'h30;
  localparam logic [7:0] CH_D9 = 8'h39;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5A;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ----------------------------------------------------------------
  // Address, field sizes and reply layout
  // ----------------------------------------------------------------
  localparam logic [13:0] ADDR_MIN = 14'h0001;
  localparam logic [13:0] ADDR_MAX = 14'h270F;
  localparam logic [13:0] ADDR_RESET = 14'h0001;
  localparam logic [2:0] ADDR_DIGITS = 3'h4;
  localparam logic [1:0] CODE_TOP = 2'h2;
  localparam logic [3:0] ARG_MAX = 4'h8;
  localparam logic [4:0] OFS_SLASH = 5'h01;
  localparam logic [4:0] OFS_CODE = 5'h02;
  localparam logic [4:0] OFS_QUAL = 5'h05;
  localparam logic [4:0] OFS_ARGS = 5'h06;
  localparam logic [4:0] REPLY_FIXED = 5'h08;

  // ----------------------------------------------------------------
  // Instruction codes checked locally (upper case)
  // ----------------------------------------------------------------
  localparam logic [23:0] CODE_SILENCE = 24'h4D5554;
  localparam logic [23:0] CODE_GAIN_CUT = 24'h415454;
  localparam logic [23:0] CODE_CLR_ALARM = 24'h434141;
  localparam logic [23:0] CODE_CAL_DAY = 24'h444154;
  localparam logic [23:0] CODE_CLK_DAY = 24'h54494D;

  typedef enum logic [2:0] {
    RSP_OK = 3'b000,
    RSP_BAD_ARG = 3'b001,
    RSP_MODE = 3'b010,
    RSP_BUSY = 3'b011,
    RSP_UNKNOWN = 3'b100
  } rpq_status_t;

  typedef struct packed {
    logic [2:0][7:0] code;
    logic query;
    logic virt;
    logic [3:0] vmod;
    logic [7:0][7:0] args;
    logic [3:0] arg_len;
  } rpq_cmd_t;

  typedef struct packed {
    rpq_status_t status;
    logic [7:0][7:0] args;
    logic [3:0] arg_len;
  } rpq_rsp_t;
endpackage
`default_nettype wire

// ### hw/rpq_qualifier.sv
// Functional notes
// - Own base address only ever holds 1 to 9999.
// - Base address is reloaded from addr_value when addr_load is high, never from the link.
// - Reply address field echoes the address characters the packet used.
// - Base, V, module number routes the command to that module.
// - Combined mode: only virtual clear-alarm, day and clock sets pass.
// - Virtual queries are forwarded in every mode.
// - Virtual silence or gain-reduction sets are never applied.
// - Forward slash must separate address from instruction code.
// - Instruction code is three letters, either case.
// - Equals qualifier asks to set the parameter from the arguments.
// - Question qualifier asks for the present value; no other qualifier.
// - Query answer: code, equals, present value as arguments.
// - Valid set is acknowledged by code and equals, no arguments.
// - Invalid set argument answered by code and question mark.
// - Unknown code answered by code and exclamation mark.
// - Set forbidden in current mode answered by code and star.
// - Resource shortage answered by code and hash.
// - Packets open with less-than; replies open with greater-than.
// - Replies end with carriage return then line feed.
// - Argument characters are digits, period and comma only.
`timescale 1ns/100ps
`default_nettype none
module rpq_qualifier (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic combined_operation_flag,
  input wire logic addr_load,
  input wire logic [13:0] addr_value,
  input wire logic rsp_valid,
  input wire rpq_pkg::rpq_rsp_t rsp,
  output rpq_pkg::rpq_cmd_t cmd,
  output logic cmd_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_drv_en_n,
  output logic [13:0] own_addr
);
  import rpq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_VMOD = 3'b010,
    ST_CODE = 3'b011,
    ST_QUAL = 3'b100,
    ST_ARGS = 3'b101,
    ST_EXEC = 3'b110,
    ST_SEND = 3'b111
  } rpq_state_t;

  rpq_state_t state;
  logic [5:0][7:0] abuf;
  logic [2:0] alen;
  logic [2:0] dcnt;
  logic [1:0] ccnt;
  logic vm_seen;
  logic [13:0] addr_acc;
  rpq_status_t rstat;
  logic [7:0][7:0] rargs;
  logic [3:0] rlen;
  logic [4:0] tx_pos;
  logic [4:0] tx_total;
  logic [7:0] reply_char;
  logic [7:0] qchar;
  logic is_digit;
  logic is_alpha;
  logic is_arg;
  logic [7:0] upper;
  logic [3:0] dval;
  logic in_parse;
  logic virt_set_never;
  logic virt_set_allowed;
  logic tx_last;

  // ----------------------------------------------------------------
  // Character classes
  // ----------------------------------------------------------------
  assign is_digit = rx_data >= CH_D0 && rx_data <= CH_D9;
  assign is_alpha = (rx_data >= CH_UA && rx_data <= CH_UZ) ||
                    (rx_data >= CH_LA && rx_data <= CH_LZ);
  assign is_arg = is_digit || rx_data == CH_DOT ||
                  rx_data == CH_COMMA;
  assign upper = (rx_data >= CH_LA) ? (rx_data & ~CASE_BIT) : rx_data;
  assign dval = 4'(rx_data - CH_D0);
  assign in_parse = state != ST_EXEC && state != ST_SEND;

  // Virtual set screening on the decoded upper-case code
  assign virt_set_never = cmd.code == CODE_SILENCE ||
                          cmd.code == CODE_GAIN_CUT;
  assign virt_set_allowed = cmd.code == CODE_CLR_ALARM ||
                            cmd.code == CODE_CAL_DAY ||
                            cmd.code == CODE_CLK_DAY;

  // ----------------------------------------------------------------
  // Packet parser and command hand-off
  // ----------------------------------------------------------------
  // Any malformed character drops the packet silently; the controller
  // gets no reply, which matches a packet it never sent us.
  always_ff @(posedge sys_clk or posedge rst) begin : parse
    if (rst) begin
      state <= ST_IDLE;
      cmd <= '0;
      cmd_valid <= 1'b0;
      abuf <= '0;
      alen <= '0;
      dcnt <= '0;
      ccnt <= '0;
      vm_seen <= 1'b0;
      addr_acc <= '0;
      rstat <= RSP_OK;
      rargs <= '0;
      rlen <= '0;
    end else begin
      cmd_valid <= 1'b0;
      if (in_parse && rx_valid && rx_data == CH_SOP_IN) begin
        state <= ST_ADDR;
        alen <= '0;
        dcnt <= '0;
        ccnt <= '0;
        vm_seen <= 1'b0;
        addr_acc <= '0;
        cmd <= '0;
      end else begin
        case (state)
          ST_ADDR: if (rx_valid) begin
            if (is_digit && dcnt < ADDR_DIGITS) begin
              addr_acc <= 14'((addr_acc << 3) + (addr_acc << 1) + dval);
              abuf[alen] <= rx_data;
              alen <= alen + 3'h1;
              dcnt <= dcnt + 3'h1;
            end else if (dcnt != '0 && (rx_data == CH_VIRT_UC ||
                                        rx_data == CH_VIRT_LC)) begin
              abuf[alen] <= rx_data;
              alen <= alen + 3'h1;
              cmd.virt <= 1'b1;
              state <= ST_VMOD;
            end else if (dcnt != '0 && rx_data == CH_SLASH) begin
              state <= ST_CODE;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_VMOD: if (rx_valid) begin
            if (is_digit && !vm_seen) begin
              abuf[alen] <= rx_data;
              alen <= alen + 3'h1;
              cmd.vmod <= dval;
              vm_seen <= 1'b1;
            end else if (vm_seen && rx_data == CH_SLASH) begin
              state <= ST_CODE;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_CODE: if (rx_valid) begin
            if (is_alpha) begin
              cmd.code[2'(CODE_TOP - ccnt)] <= upper;
              ccnt <= ccnt + 2'h1;
              if (ccnt == CODE_TOP) state <= ST_QUAL;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_QUAL: if (rx_valid) begin
            // Only assignment or query may come from the controller
            if (rx_data == CH_EQ || rx_data == CH_QRY) begin
              cmd.query <= rx_data == CH_QRY;
              state <= ST_ARGS;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_ARGS: if (rx_valid) begin
            if (is_arg && cmd.arg_len < ARG_MAX) begin
              cmd.args[3'(cmd.arg_len)] <= rx_data;
              cmd.arg_len <= cmd.arg_len + 4'h1;
            end else if (rx_data == CH_CR) begin
              if (addr_acc != own_addr) begin
                state <= ST_IDLE;
              end else if (!cmd.query && cmd.virt && (virt_set_never ||
                  (combined_operation_flag && !virt_set_allowed))) begin
                rstat <= RSP_MODE;
                rlen <= '0;
                state <= ST_SEND;
              end else begin
                cmd_valid <= 1'b1;
                state <= ST_EXEC;
              end
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_EXEC: if (rsp_valid) begin
            rstat <= rsp.status;
            rargs <= rsp.args;
            // Arguments ride only on a successful query
            rlen <= (cmd.query && rsp.status == RSP_OK) ?
                    rsp.arg_len : '0;
            state <= ST_SEND;
          end
          ST_SEND: if (tx_last) state <= ST_IDLE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Own base address
  // ----------------------------------------------------------------
  // Out-of-range loads are ignored so address 0 can never match
  always_ff @(posedge sys_clk or posedge rst) begin : base_addr
    if (rst) begin
      own_addr <= ADDR_RESET;
    end else if (addr_load && addr_value >= ADDR_MIN &&
                 addr_value <= ADDR_MAX) begin
      own_addr <= addr_value;
    end
  end

  // ----------------------------------------------------------------
  // Reply assembly
  // ----------------------------------------------------------------
  // Qualifier chosen from the outcome
  always_comb begin
    case (rstat)
      RSP_OK: qchar = CH_EQ;
      RSP_BAD_ARG: qchar = CH_QRY;
      RSP_MODE: qchar = CH_STAR;
      RSP_BUSY: qchar = CH_HASH;
      RSP_UNKNOWN: qchar = CH_BANG;
      default: qchar = CH_BANG;
    endcase
  end

  assign tx_total = 5'(alen) + 5'(rlen) + REPLY_FIXED;

  // Character at reply position tx_pos
  always_comb begin
    logic [4:0] a;
    a = 5'(alen);
    if (tx_pos == '0) begin
      reply_char = CH_SOP_OUT;
    end else if (tx_pos <= a) begin
      reply_char = abuf[3'(tx_pos - OFS_SLASH)];
    end else if (tx_pos == a + OFS_SLASH) begin
      reply_char = CH_SLASH;
    end else if (tx_pos < a + OFS_QUAL) begin
      reply_char = cmd.code[2'(CODE_TOP - 2'(tx_pos - a - OFS_CODE))];
    end else if (tx_pos == a + OFS_QUAL) begin
      reply_char = qchar;
    end else if (tx_pos < a + OFS_ARGS + 5'(rlen)) begin
      reply_char = rargs[3'(tx_pos - a - OFS_ARGS)];
    end else if (tx_pos == a + OFS_ARGS + 5'(rlen)) begin
      reply_char = CH_CR;
    end else begin
      reply_char = CH_LF;
    end
  end

  assign tx_last = tx_valid && tx_ready && tx_pos == tx_total;

  // ----------------------------------------------------------------
  // Reply transmitter
  // ----------------------------------------------------------------
  // Driver enable follows the send state but is released on the same edge
  // that takes the final line feed; bus stays free otherwise.
  always_ff @(posedge sys_clk or posedge rst) begin : transmit
    if (rst) begin
      tx_pos <= '0;
      tx_data <= '0;
      tx_valid <= 1'b0;
      tx_drv_en_n <= 1'b1;
    end else begin
      tx_drv_en_n <= !(state == ST_SEND && !tx_last);
      if (state != ST_SEND) begin
        tx_pos <= '0;
        tx_valid <= 1'b0;
      end else if ((!tx_valid || tx_ready) && tx_pos < tx_total) begin
        tx_data <= reply_char;
        tx_valid <= 1'b1;
        tx_pos <= tx_pos + 5'h01;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_addr_range;
    own_addr >= ADDR_MIN && own_addr <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("base address out of range");

  property p_addr_load;
    addr_load && addr_value >= ADDR_MIN && addr_value <= ADDR_MAX
      |=> own_addr == $past(addr_value);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("valid address load not applied");

  property p_match;
    cmd_valid |-> addr_acc == own_addr && state == ST_EXEC;
  endproperty
  a_match: assert property (p_match)
    else $error("command forwarded for foreign address");

  property p_never;
    cmd_valid && cmd.virt && !cmd.query |-> !virt_set_never;
  endproperty
  a_never: assert property (p_never)
    else $error("virtual silence or gain set forwarded");

  property p_combined;
    cmd_valid && cmd.virt && !cmd.query && $past(combined_operation_flag)
      |-> virt_set_allowed;
  endproperty
  a_combined: assert property (p_combined)
    else $error("virtual set passed in combined mode");

  property p_code_upper;
    cmd_valid |-> cmd.code[0] inside {[CH_UA:CH_UZ]} &&
      cmd.code[1] inside {[CH_UA:CH_UZ]} && cmd.code[2] inside {[CH_UA:CH_UZ]};
  endproperty
  a_code_upper: assert property (p_code_upper)
    else $error("instruction code not alphabetic");

  property p_drv;
    tx_valid |-> !tx_drv_en_n;
  endproperty
  a_drv: assert property (p_drv)
    else $error("reply sent with driver disabled");

  property p_sop;
    $fell(tx_drv_en_n) |-> tx_valid && tx_data == CH_SOP_OUT;
  endproperty
  a_sop: assert property (p_sop)
    else $error("reply does not open with start char");

  property p_end;
    tx_last |-> tx_data == CH_LF ##1 tx_drv_en_n && !tx_valid;
  endproperty
  a_end: assert property (p_end)
    else $error("reply end or driver release wrong");

  c_query: cover property (cmd_valid && cmd.query);
  c_virt_set: cover property (cmd_valid && cmd.virt && !cmd.query);
  c_local_star: cover property (state == ST_ARGS ##1
                                state == ST_SEND && rstat == RSP_MODE);
  c_reply_done: cover property (tx_last);
endmodule // rpq_qualifier
`default_nettype wire

// ### testbench/rpq_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module rpq_ctrl_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_ready
);
  import rpq_pkg::*;
  logic [7:0] got[$];
  logic [1:0] stall = 2'h0;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end

  // Reply characters are taken only on a handshake edge
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
  end

  // Slow mode accepts one character in four to stretch the reply
  always @(negedge sys_clk) begin
    stall = stall + 2'h1;
    tx_ready = !slow || stall == 2'h0;
  end

  // One packet, characters back to back, idle line shows inverted data
  task automatic send(input string body);
    rx_valid = 1'b1;
    rx_data = CH_SOP_IN;
    @(negedge sys_clk);
    for (int i = 0; i < body.len(); i++) begin
      rx_data = body[i];
      @(negedge sys_clk);
    end
    rx_data = CH_CR;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_data = ~CH_CR;
  endtask
endmodule // rpq_ctrl_model
`default_nettype wire

// ### testbench/tb_remote_packet_addr_qualifier.sv
`timescale 1ns/100ps
`default_nettype none
module tb_remote_packet_addr_qualifier;
  import rpq_pkg::*;
  typedef struct {
    string pkt;
    logic [23:0] code;
    logic comb;
    rpq_status_t st;
    string arg;
    string exp;
  } rpq_row_t;
  logic sys_clk, rst, comb_flag, slow, addr_load, rsp_valid;
  logic [13:0] addr_value, own_addr;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, tx_ready, cmd_valid, tx_valid, tx_drv_en_n;
  rpq_rsp_t rsp;
  rpq_cmd_t cmd;
  int failures, checks;
  localparam logic [23:0] LC = 24'h202020; // Case bit of each letter
  rpq_row_t rows[19];

  rpq_qualifier i_rpq_qualifier (
    .sys_clk(sys_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_ready(tx_ready), .combined_operation_flag(comb_flag),
    .addr_load(addr_load), .addr_value(addr_value), .rsp_valid(rsp_valid),
    .rsp(rsp), .cmd(cmd), .cmd_valid(cmd_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_drv_en_n(tx_drv_en_n), .own_addr(own_addr)
  );

  rpq_ctrl_model i_rpq_ctrl_model (
    .sys_clk(sys_clk), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready)
  );

  // ----------------------------------------------------------------
  // Clock and checking helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected echo carries the code folded to upper case
  function automatic string up(input string f, input logic [23:0] c);
    return (f.len() == 0) ? "" : $sformatf(f, c & ~LC);
  endfunction

  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic load(input logic [13:0] v);
    addr_value = v;
    addr_load = 1'b1;
    @(negedge sys_clk);
    addr_load = 1'b0;
    @(negedge sys_clk);
  endtask

  // Send a packet, play the application, then compare the whole reply
  task automatic run(input string pkt, input logic c, input rpq_status_t st,
                     input string arg, input string exp);
    int n;
    i_rpq_ctrl_model.got.delete();
    comb_flag = c;
    i_rpq_ctrl_model.send(pkt);
    // Answer while the one-cycle cmd_valid pulse still stands
    for (n = 0; n < 40 && tx_drv_en_n === 1'b1; n++) begin
      rsp_valid = cmd_valid;
      rsp.status = st;
      rsp.arg_len = 4'(arg.len());
      for (int k = 0; k < arg.len(); k++) rsp.args[k] = arg[k];
      @(negedge sys_clk);
    end
    rsp_valid = 1'b0;
    for (n = 0; n < 300 && tx_drv_en_n !== 1'b1; n++) @(negedge sys_clk);
    if (n == 300) begin
      failures++;
      results();
    end
    @(negedge sys_clk);
    check(tx_drv_en_n, 1'b1);
    n = (exp.len() == 0) ? 0 : exp.len() + 2;
    check(16'(i_rpq_ctrl_model.got.size()), 16'(n));
    for (n = 0; n < exp.len() && n < i_rpq_ctrl_model.got.size(); n++)
      check(i_rpq_ctrl_model.got[n], exp[n]);
    if (exp.len() > 0 && i_rpq_ctrl_model.got.size() == exp.len() + 2) begin
      check(i_rpq_ctrl_model.got[exp.len()], CH_CR);
      check(i_rpq_ctrl_model.got[exp.len() + 1], CH_LF);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    comb_flag = 1'b0;
    slow = 1'b0;
    addr_load = 1'b0;
    addr_value = 14'h0000;
    rsp_valid = 1'b0;
    rsp = '0;
    failures = 0;
    checks = 0;
    rows = '{
      '{"12/%s?", CODE_SILENCE, 1'b0, RSP_OK, "1",
        ">12/%s=1"},
      '{"0012/%s=12.25", CODE_GAIN_CUT | LC, 1'b0, RSP_OK, "",
        ">0012/%s="},
      '{"12/%s=5", 24'h414243, 1'b0, RSP_BAD_ARG, "", ">12/%s?"},
      '{"12/%s?", 24'h78797A, 1'b0, RSP_UNKNOWN, "", ">12/%s!"},
      '{"12/%s=1", 24'h414D50, 1'b0, RSP_MODE, "", ">12/%s*"},
      '{"12/%s=0", 24'h414D50, 1'b0, RSP_BUSY, "", ">12/%s#"},
      '{"12V1/%s=1", CODE_SILENCE, 1'b0, RSP_OK, "", ">12V1/%s*"},
      '{"12V2/%s=3", CODE_GAIN_CUT, 1'b1, RSP_OK, "", ">12V2/%s*"},
      '{"12V1/%s=", CODE_CLR_ALARM, 1'b1, RSP_OK, "", ">12V1/%s="},
      '{"12V2/%s=1.2", CODE_CAL_DAY | LC, 1'b1, RSP_OK, "",
        ">12V2/%s="},
      '{"12V1/%s=1", 24'h414D50, 1'b1, RSP_OK, "", ">12V1/%s*"},
      '{"12V2/%s?", CODE_SILENCE, 1'b1, RSP_OK, "2", ">12V2/%s=2"},
      '{"13/%s?", CODE_SILENCE, 1'b0, RSP_OK, "", ""},
      '{"12/MU<12/%s=", CODE_CLR_ALARM, 1'b0, RSP_OK, "",
        ">12/%s="},
      '{"12%s?", CODE_SILENCE, 1'b0, RSP_OK, "", ""},
      '{"12/%s?", 24'h4D3154, 1'b0, RSP_OK, "", ""},
      '{"12/%s!", CODE_SILENCE, 1'b0, RSP_OK, "", ""},
      '{"12/%s=1A", CODE_GAIN_CUT, 1'b0, RSP_OK, "", ""},
      '{"12345/%s?", CODE_SILENCE, 1'b0, RSP_OK, "", ""}
    };
    repeat (8) @(negedge sys_clk);
    check(tx_drv_en_n, 1'b1);
    check({tx_valid, cmd_valid}, 2'b00);
    check(own_addr, ADDR_RESET);
    rst = 1'b0;
    // Out-of-range loads must leave the address alone
    load(14'h0000);
    check(own_addr, ADDR_RESET);
    load(14'h2710);
    check(own_addr, ADDR_RESET);
    load(14'h000C);
    check(own_addr, 14'h000C);
    for (int r = 0; r < 19; r++) begin
      slow = r[0];
      run($sformatf(rows[r].pkt, rows[r].code), rows[r].comb, rows[r].st,
          rows[r].arg, up(rows[r].exp, rows[r].code));
    end
    // Forwarded virtual set keeps its fields until the next packet
    run($sformatf("12V3/%s=1", CODE_CLK_DAY | LC), 1'b1, RSP_OK, "",
        $sformatf(">12V3/%s=", CODE_CLK_DAY));
    check(cmd.code, CODE_CLK_DAY);
    check({cmd.virt, cmd.query, cmd.vmod}, 6'h23);
    check({cmd.arg_len, cmd.args[0]}, 12'h131);
    load(ADDR_MAX);
    run($sformatf("9999/%s?", CODE_SILENCE), 1'b0, RSP_OK, "2",
        $sformatf(">9999/%s=2", CODE_SILENCE));
    // Mid-run reset brings the base address back
    rst = 1'b1;
    @(negedge sys_clk);
    check(own_addr, ADDR_RESET);
    rst = 1'b0;
    @(negedge sys_clk);
    run($sformatf("1/%s=", CODE_CLR_ALARM), 1'b0, RSP_OK, "",
        $sformatf(">1/%s=", CODE_CLR_ALARM));
    results();
  end
endmodule // tb_remote_packet_addr_qualifier
`default_nettype wire
